// >>> dv/i2cs_bus_master.sv
// Behavioural two-wire bus master addressing the slave port.
// Assumes a pulled-up data line; the clock stands high between frames.
`timescale 1ns/1ns
module i2cs_bus_master (
	output logic scl,
	output logic sdaPull,
	input wire logic sdaBus
);
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end

	// ==========================================================
	// One 125 ns bit; enters and leaves with the clock low
	// Tasks last whole 5 ns steps and move lines off them, never on a clk edge
	task automatic bitCycle(input logic b, output logic s);
		#2 sdaPull = !b;
		#31 scl = 1'b1;
		#31 s = sdaBus;
		#32 scl = 1'b0;
		#29;
	endtask

	// Long gaps so the slave's synchroniser sees data move with clock high
	task automatic startCond();
		#2 sdaPull = 1'b0;
		#31 scl = 1'b1;
		#63 sdaPull = 1'b1;
		#62 scl = 1'b0;
		#32;
	endtask

	task automatic stopCond();
		#2 sdaPull = 1'b1;
		#31 scl = 1'b1;
		#63 sdaPull = 1'b0;
		#64;
	endtask

	// Most significant bit first, then the slave's acknowledge (0 = ack)
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(d[i], s);
		end
		bitCycle(1'b1, ack);
	endtask

	// Line released while the slave sends; nack ends the read
	task automatic rdByte(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(1'b1, d[i]);
		end
		bitCycle(nack, s);
	endtask
endmodule // i2cs_bus_master

// >>> dv/i2cs_top_props.sv
// Concurrent checks on the register bus handshakes and read contents of the slave port.
// Assumes a single clock domain; bound to every instance of the top module.
`timescale 1ns/1ns
module i2cs_top_props
	import i2cs_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [ADDR_W-1:0] readAddr;
	logic statusRd;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Address of the read being answered; stable while rvalid stands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readAddr <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			readAddr <= s_axi_araddr;
		end
	end
	assign statusRd = s_axi_rvalid && (readAddr == ADDR_W'(I2CS_STATUS_OFS));

	// ==========================================================
	// Register bus handshakes
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read not answered next cycle");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	bad_addr_a: assert property (s_axi_rvalid && (readAddr > ADDR_W'(I2CS_TX_OFS)
		|| readAddr[1:0] != 2'h0) |-> s_axi_rresp == I2CS_RESP_SLVERR)
		else $error("unmapped read not refused");

	// ==========================================================
	// Register contents
	mask_upper_a: assert property (s_axi_rvalid && readAddr == ADDR_W'(I2CS_MASK_OFS)
		|-> s_axi_rdata[31:10] == 22'h0) else $error("mask upper bits not zero");
	status_spare_a: assert property (statusRd
		|-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[14:6] == 9'h0)
		else $error("status spare bits not zero");
	last_cond_a: assert property (statusRd
		|-> !(s_axi_rdata[I2CS_ST_STOP] && s_axi_rdata[I2CS_ST_START]))
		else $error("start and stop both flagged");
endmodule // i2cs_top_props

bind i2cs_top i2cs_top_props #(.ADDR_W(ADDR_W)) i_props (
	.clk(clk),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// >>> dv/tb_i2c_slave_status_and_mask.sv
// Self-checking bench: register accesses and bus frames on the slave port.
// Assumes the bus master model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb_i2c_slave_status_and_mask
	import i2cs_pkg::*;
;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, scl, sdaPull;
	logic awready, wready, bvalid, arready, rvalid, sdaOut, sdaDriveN, ack;
	logic [7:0] awaddr, araddr, byteIn;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	wire sdaBus;
	int errTotal, samplesChecked;

	// Open-drain data line with pull-up
	assign sdaBus = (!sdaDriveN ? sdaOut : 1'b1) & !sdaPull;

	i2cs_top #(.ADDR_W(8)) i_dut (
		.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN)
	);

	i2cs_bus_master i_master (.scl(scl), .sdaPull(sdaPull), .sdaBus(sdaBus));

	// 100 MHz clock
	always #5 clk = ~clk;

	// ==========================================================
	// Register bus tasks; each channel released at its own handshake
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic readExp(input logic [7:0] a, input logic [31:0] exp, input string what);
		axiRead(a, rd, resp);
		checkVal(what, exp, rd);
	endtask

	// Expected status word built from field positions
	function automatic logic [31:0] stat(input logic ak, da, sp, st, rw, rf, tf);
		stat = '0;
		stat[I2CS_ST_ACK] = ak;
		stat[I2CS_ST_DA] = da;
		stat[I2CS_ST_STOP] = sp;
		stat[I2CS_ST_START] = st;
		stat[I2CS_ST_RW] = rw;
		stat[I2CS_ST_RXF] = rf;
		stat[I2CS_ST_TXF] = tf;
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		readExp(I2CS_STATUS_OFS, 32'h0, "status reset");
		readExp(I2CS_MASK_OFS, 32'h0, "mask reset");
		axiRead(8'h18, rd, resp);
		checkVal("unmapped resp", {30'h0, I2CS_RESP_SLVERR}, {30'h0, resp});
		axiWrite(8'h18, 32'h0);
		checkVal("unmapped write resp", {30'h0, I2CS_RESP_SLVERR}, {30'h0, resp});
		axiWrite(I2CS_MASK_OFS, 32'hFFFFFFFF);
		checkVal("mask write resp", {30'h0, I2CS_RESP_OKAY}, {30'h0, resp});
		readExp(I2CS_MASK_OFS, 32'h3FF, "mask width");
		axiWrite(I2CS_OWN_OFS, 32'h28);
		axiWrite(I2CS_MASK_OFS, 32'h0);
		axiWrite(I2CS_CTRL_OFS, 32'h1);
		// Write frame; status read while the clock is held low mid-frame
		i_master.startCond();
		i_master.wrByte(8'h50, ack);
		checkVal("address ack", 32'h0, {31'h0, ack});
		i_master.wrByte(8'hA5, ack);
		readExp(I2CS_STATUS_OFS, stat(0, 1, 0, 1, 0, 1, 0), "status in frame");
		i_master.stopCond();
		readExp(I2CS_STATUS_OFS, stat(0, 1, 1, 0, 0, 1, 0), "status stop");
		readExp(I2CS_RX_OFS, 32'hA5, "received byte");
		readExp(I2CS_STATUS_OFS, stat(0, 1, 1, 0, 0, 0, 0), "status after read");
		// Bit 0 ignored, upper mask bits have no effect in 7-bit mode
		axiWrite(I2CS_MASK_OFS, 32'h381);
		i_master.startCond();
		i_master.wrByte(8'h52, ack);
		checkVal("masked ack", 32'h0, {31'h0, ack});
		i_master.stopCond();
		readExp(I2CS_STATUS_OFS, stat(0, 0, 1, 0, 0, 0, 0), "status match");
		i_master.startCond();
		i_master.wrByte(8'h54, ack);
		checkVal("unmasked nack", 32'h1, {31'h0, ack});
		readExp(I2CS_STATUS_OFS, stat(0, 0, 0, 1, 0, 0, 0), "status start");
		i_master.stopCond();
		// Slave transmit ended by the master's nack
		axiWrite(I2CS_TX_OFS, 32'h3C);
		readExp(I2CS_STATUS_OFS, stat(0, 1, 1, 0, 0, 0, 1), "status tx load");
		i_master.startCond();
		i_master.wrByte(8'h51, ack);
		checkVal("read address ack", 32'h0, {31'h0, ack});
		i_master.rdByte(byteIn, 1'b1);
		i_master.stopCond();
		checkVal("sent byte", 32'h3C, {24'h0, byteIn});
		readExp(I2CS_STATUS_OFS, stat(1, 0, 1, 0, 1, 0, 0), "status tx done");
		conclude();
	end

	// Whole run is under ten microseconds; this cuts a hang short
	initial begin
		#300000;
		errTotal++;
		$display("[FAIL] watchdog expected finish seen hang");
		conclude();
	end
endmodule // tb_i2c_slave_status_and_mask

// >>> pkg/i2cs_pkg.sv
// Shared constants and types of the two-wire bus slave port.
// Assumes a 32-bit AXI4-Lite register bus and word-aligned registers.
package i2cs_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] I2CS_STATUS_OFS = 8'h00;
	localparam logic [7:0] I2CS_MASK_OFS = 8'h04;
	localparam logic [7:0] I2CS_OWN_OFS = 8'h08;
	localparam logic [7:0] I2CS_CTRL_OFS = 8'h0C;
	localparam logic [7:0] I2CS_RX_OFS = 8'h10;
	localparam logic [7:0] I2CS_TX_OFS = 8'h14;

	// ==========================================================
	// Status field positions
	localparam int I2CS_ST_ACK = 15;
	localparam int I2CS_ST_DA = 5;
	localparam int I2CS_ST_STOP = 4;
	localparam int I2CS_ST_START = 3;
	localparam int I2CS_ST_RW = 2;
	localparam int I2CS_ST_RXF = 1;
	localparam int I2CS_ST_TXF = 0;

	// Control field positions
	localparam int I2CS_CTRL_EN = 0;
	localparam int I2CS_CTRL_TEN = 1;

	// ==========================================================
	// Reset values and widths
	localparam int I2CS_ADDR_BITS = 10;
	localparam logic [9:0] I2CS_MASK_RST = 10'h000;
	localparam logic [9:0] I2CS_OWN_RST = 10'h000;
	localparam logic [1:0] I2CS_CTRL_RST = 2'h0;
	localparam logic [7:0] I2CS_TX_RST = 8'h00;
	localparam logic [3:0] I2CS_BITS_PER_BYTE = 4'h8;
	localparam logic [4:0] I2CS_TEN_HDR = 5'h1E;

	// AXI response codes
	localparam logic [1:0] I2CS_RESP_OKAY = 2'h0;
	localparam logic [1:0] I2CS_RESP_SLVERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		I2CS_IDLE = 4'h0,
		I2CS_ADDR = 4'h1,
		I2CS_ADDR_ACK = 4'h2,
		I2CS_ADDR2 = 4'h3,
		I2CS_RX = 4'h4,
		I2CS_RX_ACK = 4'h5,
		I2CS_TX = 4'h6,
		I2CS_TX_ACK = 4'h7
	} i2cs_state_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic sclRise;
		logic sclFall;
		logic sda;
	} i2cs_cond_t;

	typedef struct packed {
		logic ackResult;
		logic dataOrAddr;
		logic stopSeen;
		logic startSeen;
		logic readDir;
		logic receiveHoldingFull;
		logic transmitHoldingFull;
	} i2cs_status_t;

endpackage

// >>> src/i2cs_cond_detect.sv
// Finds bus conditions and clock edges on synchronised clock and data.
// Assumes both inputs already passed a synchroniser on clk.
`timescale 1ns/1ns
module i2cs_cond_detect
	import i2cs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	output i2cs_cond_t cond
);

	logic sclPrev;
	logic sdaPrev;

	// ==========================================================
	// Previous levels for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= scl;
			sdaPrev <= sda;
		end
	end

	// Data moving while clock stays high marks start or stop
	always_comb begin
		cond.start = sclPrev & scl & sdaPrev & ~sda;
		cond.stop = sclPrev & scl & ~sdaPrev & sda;
		cond.sclRise = ~sclPrev & scl;
		cond.sclFall = sclPrev & ~scl;
		cond.sda = sda;
	end

endmodule // i2cs_cond_detect

// >>> src/i2cs_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are slow compared to clk.
`timescale 1ns/1ns
module i2cs_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage1;

	// ==========================================================
	// Synchroniser chain; idle bus is high, so reset to ones
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '1;
			syncOut <= '1;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule // i2cs_sync

// >>> src/i2cs_top.sv
// Two-wire bus slave port with status reporting and address masking.
// Assumes an AXI4-Lite master on the register side and an external
// open-drain bus with pull-ups; the clock line is only ever listened to.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module i2cs_top
	import i2cs_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaDriveN
);

	// ==========================================================
	// Helpers

	// Byte-lane merge for the low half-word of a register
	function automatic logic [15:0] mergeLanes(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// Masked compare: a set mask bit frees that position
	function automatic logic addrMatch(input logic [9:0] got, input logic [9:0] own,
		input logic [9:0] msk);
		return ((got ^ own) & ~msk) == 10'h000;
	endfunction

	// ==========================================================
	// Declarations
	i2cs_state_t state;
	i2cs_cond_t cond;
	i2cs_status_t status;
	logic sclSync;
	logic sdaSync;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic [7:0] receiveHoldingRegister;
	logic [7:0] transmitHoldingRegister;
	logic [9:0] addressIgnoreBits;
	logic [9:0] ownAddress;
	logic [1:0] control;
	logic pendRead;
	logic needSecond;
	logic tenMatched;
	logic ackSample;
	logic evAddr;
	logic evDirValid;
	logic evDir;
	logic evRx;
	logic evTxDone;
	logic evAck;
	logic evAckVal;
	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite;
	logic txWrite;
	logic rdRxHit;
	logic [31:0] rdWord;
	logic rdErr;
	logic sevenHit;
	logic hdrHit;
	logic firstAccept;
	logic lowHit;
	logic portEnable;
	logic tenBit;

	assign portEnable = control[I2CS_CTRL_EN];
	assign tenBit = control[I2CS_CTRL_TEN];

	// ==========================================================
	// Pin conditioning
	i2cs_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn({sclIn, sdaIn}),
		.syncOut({sclSync, sdaSync})
	);

	i2cs_cond_detect u_cond (
		.clk(clk),
		.rst(rst),
		.scl(sclSync),
		.sda(sdaSync),
		.cond(cond)
	);

	// ==========================================================
	// Address decisions on the byte just shifted in
	always_comb begin
		// Only the seven received bits take part in 7-bit mode
		sevenHit = ~tenBit & addrMatch({3'h0, shiftReg[7:1]}, {3'h0, ownAddress[6:0]},
			{3'h7, addressIgnoreBits[6:0]});
		hdrHit = tenBit & (shiftReg[7:3] == I2CS_TEN_HDR) & addrMatch({8'h00,
			shiftReg[2:1]}, {8'h00, ownAddress[9:8]}, {8'hFF, addressIgnoreBits[9:8]});
		// A read header is only honoured after a full 10-bit write match
		firstAccept = sevenHit | (hdrHit & (~shiftReg[0] | tenMatched));
		lowHit = addrMatch({2'h0, shiftReg}, {2'h0, ownAddress[7:0]},
			{2'h3, addressIgnoreBits[7:0]});
	end

	// ==========================================================
	// Bus-side state machine
	// Samples data on clock rise and changes data on clock fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= I2CS_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			sdaDriveN <= 1'b1;
			pendRead <= 1'b0;
			needSecond <= 1'b0;
			tenMatched <= 1'b0;
			ackSample <= 1'b1;
			receiveHoldingRegister <= 8'h00;
			evAddr <= 1'b0;
			evDirValid <= 1'b0;
			evDir <= 1'b0;
			evRx <= 1'b0;
			evTxDone <= 1'b0;
			evAck <= 1'b0;
			evAckVal <= 1'b0;
		end else begin
			evAddr <= 1'b0;
			evDirValid <= 1'b0;
			evRx <= 1'b0;
			evTxDone <= 1'b0;
			evAck <= 1'b0;
			if (!portEnable) begin
				state <= I2CS_IDLE;
				sdaDriveN <= 1'b1;
				tenMatched <= 1'b0;
			end else if (cond.start) begin
				state <= I2CS_ADDR;
				bitCnt <= 4'h0;
				sdaDriveN <= 1'b1;
			end else if (cond.stop) begin
				state <= I2CS_IDLE;
				sdaDriveN <= 1'b1;
				tenMatched <= 1'b0;
			end else begin
				unique case (state)
					I2CS_IDLE: begin
						sdaDriveN <= 1'b1;
					end
					I2CS_ADDR, I2CS_ADDR2, I2CS_RX: begin
						if (cond.sclRise && bitCnt != I2CS_BITS_PER_BYTE) begin
							shiftReg <= {shiftReg[6:0], cond.sda};
							bitCnt <= bitCnt + 4'h1;
						end else if (cond.sclFall && bitCnt == I2CS_BITS_PER_BYTE) begin
							bitCnt <= 4'h0;
							if (state == I2CS_ADDR) begin
								if (firstAccept) begin
									sdaDriveN <= 1'b0;
									state <= I2CS_ADDR_ACK;
									pendRead <= shiftReg[0];
									needSecond <= tenBit & ~shiftReg[0];
									evAddr <= ~(tenBit & ~shiftReg[0]);
									evDirValid <= 1'b1;
									evDir <= shiftReg[0];
								end else begin
									state <= I2CS_IDLE;
									tenMatched <= 1'b0;
								end
							end else if (state == I2CS_ADDR2) begin
								if (lowHit) begin
									sdaDriveN <= 1'b0;
									state <= I2CS_ADDR_ACK;
									needSecond <= 1'b0;
									tenMatched <= 1'b1;
									evAddr <= 1'b1;
								end else begin
									state <= I2CS_IDLE;
								end
							end else begin
								// Keep an unread byte; refuse the new one with a NACK
								receiveHoldingRegister <= status.receiveHoldingFull ?
									receiveHoldingRegister : shiftReg;
								evRx <= ~status.receiveHoldingFull;
								sdaDriveN <= status.receiveHoldingFull;
								state <= I2CS_RX_ACK;
							end
						end
					end
					I2CS_ADDR_ACK: begin
						if (cond.sclFall) begin
							bitCnt <= 4'h0;
							if (needSecond) begin
								sdaDriveN <= 1'b1;
								state <= I2CS_ADDR2;
							end else if (pendRead) begin
								shiftReg <= transmitHoldingRegister;
								sdaDriveN <= transmitHoldingRegister[7];
								state <= I2CS_TX;
							end else begin
								sdaDriveN <= 1'b1;
								state <= I2CS_RX;
							end
						end
					end
					I2CS_RX_ACK: begin
						if (cond.sclFall) begin
							sdaDriveN <= 1'b1;
							state <= I2CS_RX;
						end
					end
					I2CS_TX: begin
						if (cond.sclRise) begin
							bitCnt <= bitCnt + 4'h1;
						end else if (cond.sclFall) begin
							if (bitCnt == I2CS_BITS_PER_BYTE) begin
								sdaDriveN <= 1'b1;
								state <= I2CS_TX_ACK;
							end else begin
								shiftReg <= {shiftReg[6:0], 1'b1};
								sdaDriveN <= shiftReg[6];
							end
						end
					end
					I2CS_TX_ACK: begin
						if (cond.sclRise) begin
							ackSample <= cond.sda;
							evAck <= 1'b1;
							evAckVal <= cond.sda;
							evTxDone <= 1'b1;
						end else if (cond.sclFall) begin
							bitCnt <= 4'h0;
							if (!ackSample) begin
								shiftReg <= transmitHoldingRegister;
								sdaDriveN <= transmitHoldingRegister[7];
								state <= I2CS_TX;
							end else begin
								state <= I2CS_IDLE;
							end
						end
					end
					default: begin
						state <= I2CS_IDLE;
						sdaDriveN <= 1'b1;
					end
				endcase
			end
		end
	end

	// Open-drain: the data level is always low, only the enable moves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

	// ==========================================================
	// Status flags; hardware sets always win over clears
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else begin
			if (evAck) begin
				status.ackResult <= evAckVal;
			end
			if (evRx || txWrite) begin
				status.dataOrAddr <= 1'b1;
			end else if (evAddr) begin
				status.dataOrAddr <= 1'b0;
			end
			if (cond.start) begin
				status.startSeen <= 1'b1;
				status.stopSeen <= 1'b0;
			end else if (cond.stop) begin
				status.startSeen <= 1'b0;
				status.stopSeen <= 1'b1;
			end
			if (evDirValid) begin
				status.readDir <= evDir;
			end
			if (evRx) begin
				status.receiveHoldingFull <= 1'b1;
			end else if (rdRxHit) begin
				status.receiveHoldingFull <= 1'b0;
			end
			if (txWrite) begin
				status.transmitHoldingFull <= 1'b1;
			end else if (evTxDone) begin
				status.transmitHoldingFull <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write channel; address and data may come in either order
	assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
	assign txWrite = doWrite & (awAddr[7:0] == I2CS_TX_OFS) & wStrb[0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= I2CS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr[7:0] > I2CS_TX_OFS || awAddr[1:0] != 2'h0) ?
					I2CS_RESP_SLVERR : I2CS_RESP_OKAY;
			end
			// One write at a time: channels reopen only after the response
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Writable registers; status and receive buffer ignore writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addressIgnoreBits <= I2CS_MASK_RST;
			ownAddress <= I2CS_OWN_RST;
			control <= I2CS_CTRL_RST;
			transmitHoldingRegister <= I2CS_TX_RST;
		end else if (doWrite) begin
			unique case (awAddr[7:0])
				I2CS_MASK_OFS: begin
					addressIgnoreBits <= 10'(mergeLanes({6'h00, addressIgnoreBits}, wData,
						wStrb));
				end
				I2CS_OWN_OFS: begin
					ownAddress <= 10'(mergeLanes({6'h00, ownAddress}, wData, wStrb));
				end
				I2CS_CTRL_OFS: begin
					control <= 2'(mergeLanes({14'h0000, control}, wData, wStrb));
				end
				I2CS_TX_OFS: begin
					transmitHoldingRegister <= 8'(mergeLanes({8'h00, transmitHoldingRegister},
						wData, wStrb));
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign rdRxHit = s_axi_arvalid & s_axi_arready & (s_axi_araddr[7:0] == I2CS_RX_OFS);

	// Read mux; bits above each register read zero
	always_comb begin
		rdWord = 32'h0000_0000;
		rdErr = 1'b0;
		unique case (s_axi_araddr[7:0])
			I2CS_STATUS_OFS: begin
				rdWord[I2CS_ST_ACK] = status.ackResult;
				rdWord[I2CS_ST_DA] = status.dataOrAddr;
				rdWord[I2CS_ST_STOP] = status.stopSeen;
				rdWord[I2CS_ST_START] = status.startSeen;
				rdWord[I2CS_ST_RW] = status.readDir;
				rdWord[I2CS_ST_RXF] = status.receiveHoldingFull;
				rdWord[I2CS_ST_TXF] = status.transmitHoldingFull;
			end
			I2CS_MASK_OFS: begin
				rdWord[9:0] = addressIgnoreBits;
			end
			I2CS_OWN_OFS: begin
				rdWord[9:0] = ownAddress;
			end
			I2CS_CTRL_OFS: begin
				rdWord[1:0] = control;
			end
			I2CS_RX_OFS: begin
				rdWord[7:0] = receiveHoldingRegister;
			end
			I2CS_TX_OFS: begin
				rdWord[7:0] = transmitHoldingRegister;
			end
			default: begin
				rdErr = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= I2CS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdWord;
				s_axi_rresp <= rdErr ? I2CS_RESP_SLVERR : I2CS_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // i2cs_top
